// ==== dv/mans_partner.sv ====
`default_nettype none
// Link partner: one base page, then the finish pulse
module mans_partner (
  input  wire logic        pclk,
  input  wire logic        autoneg_active,
  input  wire logic        slow,
  input  wire logic [15:0] page,
  output logic             page_rx_valid,
  output logic      [15:0] page_rx_data,
  output logic             autoneg_finished
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle data is the inverse of the last page, so stale capture shows up
  initial begin
    page_rx_valid = 0;
    autoneg_finished = 0;
    page_rx_data = 0;
    forever begin
      @(posedge pclk iff autoneg_active);
      repeat (slow ? 6 : 1) @(posedge pclk);
      page_rx_valid <= 1;
      page_rx_data <= page;
      @(posedge pclk);
      page_rx_valid <= 0;
      page_rx_data <= ~page;
      repeat (2) @(posedge pclk);
      autoneg_finished <= 1;
      @(posedge pclk);
      autoneg_finished <= 0;
    end
  end
endmodule
`default_nettype wire

// ==== dv/mans_props.sv ====
`default_nettype none
// Port-level checks on the autoneg register slave
module mans_props import mans_pkg::*; (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        link_up_in,
  input wire logic        autoneg_finished,
  input wire logic        autoneg_start,
  input wire logic        autoneg_active
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rd_set;
  // Read setup cycle; prdata is loaded at this edge and checked one later
  assign rd_set = psel && !penable && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_start_act: assert property (autoneg_start |=> autoneg_active)
    else $error("start pulse without negotiation");
  a_start_once: assert property (autoneg_start |=> !autoneg_start)
    else $error("restart did not self clear");
  a_done_idle: assert property (autoneg_active && autoneg_finished |=> !autoneg_active)
    else $error("finish did not end negotiation");
  a_able_one: assert property (rd_set && paddr == ADDR_AUTONEG_STATUS
    |=> (prdata & 32'hFFFFFFDB) == 32'h8) else $error("status fixed bits wrong");
  a_link_mirror: assert property (rd_set && paddr == ADDR_AUTONEG_STATUS
    |=> prdata[2] == $past(link_up_in, 2)) else $error("link bit does not follow link");
  a_adv_fixed: assert property (rd_set && paddr == ADDR_AUTONEG_LOCAL_ADVERT
    |=> (prdata & 32'hFFFFCE1F) == 0) else $error("advert fixed bits not zero");
  a_exp_fixed: assert property (rd_set && paddr == ADDR_AUTONEG_EXPANSION
    |=> (prdata & 32'hFFFFFFFD) == 0) else $error("expansion fixed bits not zero");
  a_unmapped_err: assert property (psel && penable && paddr[31:8] != 0 |-> pslverr)
    else $error("no error on unmapped access");
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`default_nettype none
module tb_top import mans_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] A_CT = ADDR_AUTONEG_CTRL, A_ST = ADDR_AUTONEG_STATUS,
    A_AD = ADDR_AUTONEG_LOCAL_ADVERT, A_PA = ADDR_AUTONEG_PARTNER_ABILITY,
    A_EX = ADDR_AUTONEG_EXPANSION;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        link_up_in = 0, slow = 0, pready, pslverr, page_rx_valid;
  logic        autoneg_finished, autoneg_active, autoneg_start;
  logic [31:0] paddr = 0, pwdata = 0, prdata, seed = 32'hBAEA0B1C, qe[$], qm[$];
  logic [15:0] page = 0, page_rx_data, local_page, local_page_fd;
  int          mismatches = 0, n_tests = 0, cyc = 0;
  always #12.5 pclk = ~pclk;
  mans_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .link_up_in, .page_rx_valid, .page_rx_data, .autoneg_finished,
    .autoneg_active, .autoneg_start, .local_page);
  mans_partner i_far (.pclk, .autoneg_active, .slow, .page, .page_rx_valid,
    .page_rx_data, .autoneg_finished);
  // Full-duplex-only build on the same bus; the test checks only its page, the bound props check its ports
  mans_regs #(.FULL_DUPLEX_ONLY(1'b1)) i_dut_fd (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata(), .pready(), .pslverr(), .link_up_in, .page_rx_valid,
    .page_rx_data, .autoneg_finished, .autoneg_active(), .autoneg_start(),
    .local_page(local_page_fd));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic wrap_up();
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_pg(input logic [15:0] g, e);
    chk({16'h0000, g}, {16'h0000, e});
  endtask
  // One APB transfer; expected read data is noted at setup
  task automatic xfer(input logic w, input logic [31:0] a, d, e, m);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) qe.push_back(e);
    if (!w) qm.push_back(m);
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [31:0] a, d);
    xfer(1, a, d, 0, 0);
  endtask
  task automatic rd(input logic [31:0] a, e, m = 32'hFFFFFFFF);
    xfer(0, a, 0, e, m);
  endtask
  // Bounded wait for the partner's finish pulse
  task automatic wneg();
    int n;
    for (n = 0; n < 40 && autoneg_finished !== 1'b1; n++) @(posedge pclk);
    if (n == 40) mismatches++;
  endtask
  // Read monitor takes the oldest note at each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) chk(prdata & qm.pop_front(), qe.pop_front());
  end
  // Hang guard, well above the sequence length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rd(A_ST, 32'h8);
    rd(A_AD, 32'h1E0);
    chk_pg(local_page_fd, 16'h01A0);
    rd(A_PA, 0);
    rd(A_EX, 0);
    wr(A_ST, 0);
    wr(A_PA, 32'hFFFFFFFF);
    wr(32'h1C8, 0);
    rd(A_ST, 32'h8);
    rd(A_PA, 0);
    rd(32'h1C8, 0);
    repeat (3) begin
      seed = xs(seed);
      wr(A_AD, seed);
      rd(A_AD, seed & 32'h31E0);
      chk_pg(local_page, seed[15:0] & 16'h31E0);
      chk_pg(local_page_fd, seed[15:0] & 16'h31A0);
    end
    link_up_in <= 1;
    repeat (2) @(posedge pclk);
    rd(A_ST, 32'hC);
    // Slow partner first, then a prompt one
    repeat (2) begin
      seed = xs(seed);
      page <= seed[15:0];
      slow <= ~slow;
      wr(A_CT, 32'h1200);
      @(posedge pclk);
      rd(A_ST, 32'h8, 32'hFFFFFFFB);
      wneg();
      rd(A_ST, 32'h2C);
      rd(A_CT, 32'h1000);
      rd(A_PA, seed & 32'hF1E0);
      rd(A_EX, 32'h2);
      rd(A_EX, 32'h0);
    end
    // Restart while disabled stays pending and leaves the flags alone
    wr(A_CT, 32'h200);
    repeat (12) @(posedge pclk);
    rd(A_CT, 32'h200);
    rd(A_ST, 32'h2C);
    rd(A_EX, 0);
    // Reset in mid-run: captured partner fields and advert go back
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(A_PA, 0);
    rd(A_AD, 32'h1E0);
    wrap_up();
  end
endmodule
bind mans_regs mans_props i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pslverr, .link_up_in, .autoneg_finished, .autoneg_start, .autoneg_active);
`default_nettype wire

// ==== include/mans_pkg.sv ====
`default_nettype none
package mans_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_AUTONEG_CTRL            = 8'hC0;
  localparam logic [7:0] ADDR_AUTONEG_STATUS          = 8'hC4;
  localparam logic [7:0] ADDR_AUTONEG_LOCAL_ADVERT    = 8'hC8;
  localparam logic [7:0] ADDR_AUTONEG_PARTNER_ABILITY = 8'hCC;
  localparam logic [7:0] ADDR_AUTONEG_EXPANSION       = 8'hD0;

  // Control register fields
  localparam int BIT_AUTONEG_ENABLE  = 12;
  localparam int BIT_AUTONEG_RESTART = 9;

  // Status register fields
  localparam int BIT_AUTONEG_DONE      = 5;
  localparam int BIT_AUTONEG_SUPPORTED = 3;
  localparam int BIT_LINK_UP           = 2;

  // Advertisement and partner page fields (same layout on both)
  localparam int BIT_NEXT_PAGE     = 15;
  localparam int BIT_ACK           = 14;
  localparam int LSB_REMOTE_FAULT  = 12;
  localparam int LSB_PAUSE         = 7;
  localparam int BIT_HALF_DUPLEX   = 6;
  localparam int BIT_FULL_DUPLEX   = 5;

  // Expansion register fields
  localparam int BIT_NEXT_PAGE_ABILITY = 2;
  localparam int BIT_NEW_PAGE          = 1;

  // Values after reset, and the ability bit that stays high
  localparam logic [1:0] RST_REMOTE_FAULT = 2'h0;
  localparam logic [1:0] RST_PAUSE        = 2'h3;
  localparam logic       RST_HALF_DUPLEX  = 1'h1;
  localparam logic       RST_FULL_DUPLEX  = 1'h1;
  localparam logic       AUTONEG_ABLE     = 1'h1;
  localparam logic [15:0] RST_PARTNER_PAGE = 16'h0000;

  // Negotiation progress
  typedef enum logic [1:0] {
    MANS_IDLE,
    MANS_NEGOTIATING,
    MANS_COMPLETE
  } mans_state_e;
endpackage
`default_nettype wire

// ==== verilog/mans_regs.sv ====
`default_nettype none
module mans_regs
  import mans_pkg::*;
#(
  parameter bit FULL_DUPLEX_ONLY = 1'b0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        link_up_in,
  input  wire logic        page_rx_valid,
  input  wire logic [15:0] page_rx_data,
  input  wire logic        autoneg_finished,
  output logic             autoneg_active,
  output logic             autoneg_start,
  output logic      [15:0] local_page
);

  // Word-aligned decode inside this block's window
  function automatic logic is_mapped(input logic [31:0] addr);
    logic [7:0] off;
    off = addr[7:0];
    return (addr[31:8] == 24'h000000) && (addr[1:0] == 2'h0) &&
           (off == ADDR_AUTONEG_CTRL || off == ADDR_AUTONEG_STATUS ||
            off == ADDR_AUTONEG_LOCAL_ADVERT || off == ADDR_AUTONEG_PARTNER_ABILITY ||
            off == ADDR_AUTONEG_EXPANSION);
  endfunction

  // One register selected by a word-aligned byte address
  function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] off);
    return (addr[31:8] == 24'h000000) && (addr[7:0] == off);
  endfunction

  // Control word: enable and pending restart, all else zero
  function automatic logic [31:0] ctrl_word(input logic enable, input logic restart);
    logic [31:0] w;
    w = 32'h00000000;
    w[BIT_AUTONEG_ENABLE]  = enable;
    w[BIT_AUTONEG_RESTART] = restart;
    return w;
  endfunction

  // Status word; the ability bit is wired high
  function automatic logic [31:0] status_word(input logic done, input logic link);
    logic [31:0] w;
    w = 32'h00000000;
    w[BIT_AUTONEG_DONE]      = done;
    w[BIT_AUTONEG_SUPPORTED] = AUTONEG_ABLE;
    w[BIT_LINK_UP]           = link;
    return w;
  endfunction

  // Advertisement word: the page as sent, upper half reserved
  function automatic logic [31:0] advert_word(input logic [15:0] page);
    logic [31:0] w;
    w = 32'h00000000;
    w[15:0] = page;
    return w;
  endfunction

  // Partner word from the captured base page fields
  function automatic logic [31:0] partner_word(
    input logic       next_page,
    input logic       ack,
    input logic [1:0] fault,
    input logic [1:0] pause,
    input logic       half,
    input logic       full
  );
    logic [31:0] w;
    w = 32'h00000000;
    w[BIT_NEXT_PAGE]         = next_page;
    w[BIT_ACK]               = ack;
    w[LSB_REMOTE_FAULT +: 2] = fault;
    w[LSB_PAUSE +: 2]        = pause;
    w[BIT_HALF_DUPLEX]       = half;
    w[BIT_FULL_DUPLEX]       = full;
    return w;
  endfunction

  // Expansion word; next page ability stays low
  function automatic logic [31:0] expansion_word(input logic new_page);
    logic [31:0] w;
    w = 32'h00000000;
    w[BIT_NEXT_PAGE_ABILITY] = 1'b0;
    w[BIT_NEW_PAGE]          = new_page;
    return w;
  endfunction

  mans_state_e state;
  mans_state_e next_state;
  logic        autoneg_enable;
  logic        autoneg_restart;
  logic        autoneg_done;
  logic        link_up_flag;
  logic [1:0]  remote_fault_code;
  logic [1:0]  pause_capability;
  logic        half_duplex_capable;
  logic        full_duplex_capable;
  logic        partner_next_page;
  logic        partner_ack;
  logic [1:0]  partner_fault;
  logic [1:0]  partner_pause;
  logic        partner_half;
  logic        partner_full;
  logic        new_page_flag;
  logic        wr_access;
  logic        rd_access;
  logic        start_now;
  logic        page_take;
  logic        wr_ctrl;
  logic        wr_advert;
  logic        rd_expansion;
  logic [31:0] rd_word;

  // Zero-wait slave: every access completes in its first access cycle
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !is_mapped(paddr);
  assign wr_access = psel && penable && pwrite && is_mapped(paddr);
  assign rd_access = psel && penable && !pwrite && is_mapped(paddr);

  // Per-register strobes, decoded once
  assign wr_ctrl      = wr_access && reg_hit(paddr, ADDR_AUTONEG_CTRL);
  assign wr_advert    = wr_access && reg_hit(paddr, ADDR_AUTONEG_LOCAL_ADVERT);
  assign rd_expansion = rd_access && reg_hit(paddr, ADDR_AUTONEG_EXPANSION);
  assign page_take    = autoneg_active && page_rx_valid;

  // Negotiation starts on a pending restart while enabled
  assign start_now      = autoneg_enable && autoneg_restart;
  assign autoneg_active = (state == MANS_NEGOTIATING);
  assign autoneg_start  = start_now;

  // Enable: software owned, negotiation runs only while set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      autoneg_enable <= 1'b0;
    end else if (wr_ctrl) begin
      autoneg_enable <= pwdata[BIT_AUTONEG_ENABLE];
    end
  end

  // Restart request stays pending until enable lets it start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      autoneg_restart <= 1'b0;
    end else if (wr_ctrl) begin
      autoneg_restart <= pwdata[BIT_AUTONEG_RESTART];
    end else if (start_now) begin
      autoneg_restart <= 1'b0;
    end
  end

  // Negotiation progress; disable abandons any exchange
  always_comb begin
    next_state = state;
    case (state)
      MANS_IDLE:        if (start_now) next_state = MANS_NEGOTIATING;
      MANS_NEGOTIATING: if (autoneg_finished) next_state = MANS_COMPLETE;
      MANS_COMPLETE:    if (start_now) next_state = MANS_NEGOTIATING;
      default:          next_state = MANS_IDLE;
    endcase
    if (!autoneg_enable) begin
      next_state = MANS_IDLE;
    end else if (start_now) begin
      next_state = MANS_NEGOTIATING;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= MANS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Done flag: a restart clears it even if the finish pulse coincides
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      autoneg_done <= 1'b0;
    end else if (start_now) begin
      autoneg_done <= 1'b0;
    end else if (autoneg_active && autoneg_finished && autoneg_enable) begin
      autoneg_done <= 1'b1;
    end
  end

  // Link state follows the link input one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_up_flag <= 1'b0;
    end else begin
      link_up_flag <= link_up_in;
    end
  end

  // Local remote fault code, sent in the page
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_fault_code <= RST_REMOTE_FAULT;
    end else if (wr_advert) begin
      remote_fault_code <= pwdata[LSB_REMOTE_FAULT +: 2];
    end
  end

  // Local pause capability
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_capability <= RST_PAUSE;
    end else if (wr_advert) begin
      pause_capability <= pwdata[LSB_PAUSE +: 2];
    end
  end

  // Half duplex; a full-duplex-only build keeps it low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_duplex_capable <= FULL_DUPLEX_ONLY ? 1'b0 : RST_HALF_DUPLEX;
    end else if (wr_advert) begin
      half_duplex_capable <= FULL_DUPLEX_ONLY ? 1'b0 : pwdata[BIT_HALF_DUPLEX];
    end
  end

  // Full duplex advertisement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_duplex_capable <= RST_FULL_DUPLEX;
    end else if (wr_advert) begin
      full_duplex_capable <= pwdata[BIT_FULL_DUPLEX];
    end
  end

  // Page sent to the partner; next page stays low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_page <= 16'h0000;
    end else begin
      local_page <= '0;
      local_page[BIT_NEXT_PAGE]            <= 1'b0;
      local_page[LSB_REMOTE_FAULT +: 2]    <= remote_fault_code;
      local_page[LSB_PAUSE +: 2]           <= pause_capability;
      local_page[BIT_HALF_DUPLEX]          <= half_duplex_capable;
      local_page[BIT_FULL_DUPLEX]          <= full_duplex_capable;
    end
  end

  // Partner next page bit, taken from each accepted page
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partner_next_page <= RST_PARTNER_PAGE[BIT_NEXT_PAGE];
    end else if (page_take) begin
      partner_next_page <= page_rx_data[BIT_NEXT_PAGE];
    end
  end

  // Partner acknowledge of our base page
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partner_ack <= RST_PARTNER_PAGE[BIT_ACK];
    end else if (page_take) begin
      partner_ack <= page_rx_data[BIT_ACK];
    end
  end

  // Partner remote fault code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partner_fault <= RST_PARTNER_PAGE[LSB_REMOTE_FAULT +: 2];
    end else if (page_take) begin
      partner_fault <= page_rx_data[LSB_REMOTE_FAULT +: 2];
    end
  end

  // Partner pause code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partner_pause <= RST_PARTNER_PAGE[LSB_PAUSE +: 2];
    end else if (page_take) begin
      partner_pause <= page_rx_data[LSB_PAUSE +: 2];
    end
  end

  // Partner half duplex ability
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partner_half <= RST_PARTNER_PAGE[BIT_HALF_DUPLEX];
    end else if (page_take) begin
      partner_half <= page_rx_data[BIT_HALF_DUPLEX];
    end
  end

  // Partner full duplex ability
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partner_full <= RST_PARTNER_PAGE[BIT_FULL_DUPLEX];
    end else if (page_take) begin
      partner_full <= page_rx_data[BIT_FULL_DUPLEX];
    end
  end

  // New page flag; a page beats a read, and only a reported flag clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      new_page_flag <= 1'b0;
    end else if (page_take) begin
      new_page_flag <= 1'b1;
    end else if (rd_expansion && prdata[BIT_NEW_PAGE]) begin
      new_page_flag <= 1'b0;
    end
  end

  // Read word assembly; unlisted bits stay zero
  always_comb begin
    rd_word = 32'h00000000;
    case (paddr[7:0])
      ADDR_AUTONEG_CTRL: begin
        rd_word = ctrl_word(autoneg_enable, autoneg_restart);
      end
      ADDR_AUTONEG_STATUS: begin
        rd_word = status_word(autoneg_done, link_up_flag);
      end
      ADDR_AUTONEG_LOCAL_ADVERT: begin
        rd_word = advert_word(local_page);
      end
      ADDR_AUTONEG_PARTNER_ABILITY: begin
        rd_word = partner_word(partner_next_page, partner_ack, partner_fault,
                               partner_pause, partner_half, partner_full);
      end
      ADDR_AUTONEG_EXPANSION: begin
        rd_word = expansion_word(new_page_flag);
      end
      default: rd_word = 32'h00000000;
    endcase
    if (!is_mapped(paddr)) begin
      rd_word = 32'h00000000;
    end
  end

  // Read data latched in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_word;
    end
  end

endmodule
`default_nettype wire
